//--- cmit_pkg.sv
// Constants for the compare match interval timer: register map,
// field positions, reset values and prescaler masks.
// Assumes a 32-bit AXI4-Lite register bus with 12 decoded address bits.
package cmit_pkg;

  // Printed register offsets, kept as register indices
  localparam logic [31:0] START_IDX = 32'hA4002070;
  localparam logic [31:0] CTRL_IDX  = 32'hA4002072;
  localparam logic [31:0] COUNT_IDX = 32'hA4002074;
  localparam logic [31:0] CONST_IDX = 32'hA4002076;

  // Byte addresses: four times the index, low 12 bits decoded
  localparam logic [11:0] START_ADDR = {START_IDX[9:0], 2'b00};
  localparam logic [11:0] CTRL_ADDR  = {CTRL_IDX[9:0], 2'b00};
  localparam logic [11:0] COUNT_ADDR = {COUNT_IDX[9:0], 2'b00};
  localparam logic [11:0] CONST_ADDR = {CONST_IDX[9:0], 2'b00};
  localparam logic [11:0] IRQ_STAT_ADDR = 12'h1E0;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h1E4;

  // Field positions
  localparam int RUN_BIT  = 0;
  localparam int FLAG_BIT = 7;
  localparam int REQ_LO   = 4;
  localparam int DIV_LO   = 0;

  // Writable bits of the control/status register (flag excluded)
  localparam logic [15:0] CTRL_WMASK  = 16'h0033;
  localparam logic [15:0] START_WMASK = 16'h0001;

  // Values after reset
  localparam logic [15:0] START_RST = 16'h0000;
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] CONST_RST = 16'hFFFF;
  localparam logic [15:0] ZERO16    = 16'h0000;

  // Request select codes
  localparam logic [1:0] REQ_NONE = 2'h0;
  localparam logic [1:0] REQ_DMA  = 2'h1;
  localparam logic [1:0] REQ_IRQ  = 2'h2;

  // Prescaler masks: tick when all masked bits are one
  localparam logic [5:0] DIV4_MASK  = 6'h03;
  localparam logic [5:0] DIV8_MASK  = 6'h07;
  localparam logic [5:0] DIV16_MASK = 6'h0F;
  localparam logic [5:0] DIV64_MASK = 6'h3F;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : cmit_pkg

//--- cmit_timer.sv
// Compare match interval timer: prescaler, 16-bit up-counter, match
// flag, DMA and interrupt requests, AXI4-Lite register slave.
// Assumes one clock; DMA acknowledge and clock stop come from logic
// on the same clock. Standby is not seen here, so state is kept.
// Operation
// R1: 16-bit up-counter, one step per tick
// R2: divider select gives /4, /8, /16, /64
// R3: run bit stops or starts counting
// R4: match clears counter, sets flag, continues
// R5: match acts on the tick after equality
// R6: request select: none, DMA, interrupt, reserved
// R7: DMA acknowledge drops request, keeps flag
// R8: interrupt request holds until flag cleared
// R9: flag clears by zero after read one
// R10: reserved bits read zero
// R11: reset values zero, constant all ones
// R12: standby keeps every timer register
// R13: constant register fully read/write interval
// R14: stopped clock supply halts all activity; here only the prescaler and counter halt, bus and request outputs keep working
// R15: counter write beats increment and clear
`timescale 1ns/1ps
module cmit_timer
  import cmit_pkg::*;
#(
  parameter int ADDR_W = 12                    // Address width; low 12 bits decoded
) (
  input  wire logic              ref_clk_i,     // 20 MHz clock
  input  wire logic              rst_b_i,       // Async reset, low
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write address
  input  wire logic              s_axi_awvalid, // Write address valid
  output logic                   s_axi_awready, // Write address ready
  input  wire logic [31:0]       s_axi_wdata,   // Write data
  input  wire logic [3:0]        s_axi_wstrb,   // Write byte lanes
  input  wire logic              s_axi_wvalid,  // Write data valid
  output logic                   s_axi_wready,  // Write data ready
  output logic [1:0]             s_axi_bresp,   // Write response
  output logic                   s_axi_bvalid,  // Write response valid
  input  wire logic              s_axi_bready,  // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,  // Read address
  input  wire logic              s_axi_arvalid, // Read address valid
  output logic                   s_axi_arready, // Read address ready
  output logic [31:0]            s_axi_rdata,   // Read data
  output logic [1:0]             s_axi_rresp,   // Read response
  output logic                   s_axi_rvalid,  // Read data valid
  input  wire logic              s_axi_rready,  // Read data ready
  input  wire logic              clk_stop_i,    // Halts timer activity
  input  wire logic              dma_ack_i,     // DMA controller accepts
  output logic                   dma_req_o,     // DMA transfer request
  output logic                   match_irq_o,   // Match interrupt request
  output logic                   irq_o          // Masked event interrupt
);

  // Refuse address widths that cannot hold the map
  if (ADDR_W < 12) begin : g_chk
    $error("cmit_timer: ADDR_W must be at least 12");
  end

  // Register state
  logic        run;
  logic [1:0]  req_sel;
  logic [1:0]  div_sel;
  logic        match_flag;
  logic        clr_armed;
  logic [15:0] count;
  logic [15:0] cnst;
  logic [5:0]  presc;
  logic        evt_stat;
  logic        evt_mask;

  // Write channel holding state
  logic              aw_full;
  logic              w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;

  // Byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge16

  // Write decode: one write commits when address and data are both held
  logic        do_write;
  logic        wr_start;
  logic        wr_ctrl;
  logic        wr_count;
  logic        wr_const;
  logic        wr_stat;
  logic        wr_mask;
  logic        wr_hit;
  logic [11:0] wa;

  always_comb begin
    do_write = aw_full && w_full && !s_axi_bvalid;
    wa       = aw_addr[11:0];
    wr_start = 1'b0;
    wr_ctrl  = 1'b0;
    wr_count = 1'b0;
    wr_const = 1'b0;
    wr_stat  = 1'b0;
    wr_mask  = 1'b0;
    wr_hit   = 1'b1;
    if (wa == START_ADDR) begin
      wr_start = do_write;
    end else if (wa == CTRL_ADDR) begin
      wr_ctrl = do_write;
    end else if (wa == COUNT_ADDR) begin
      wr_count = do_write;
    end else if (wa == CONST_ADDR) begin
      wr_const = do_write;
    end else if (wa == IRQ_STAT_ADDR) begin
      wr_stat = do_write;
    end else if (wa == IRQ_MASK_ADDR) begin
      wr_mask = do_write;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // Prescaler tick for the selected division
  logic [5:0] div_mask;
  logic       active;
  logic       tick;
  logic       match;

  always_comb begin
    case (div_sel)
      2'h0:    div_mask = DIV4_MASK;   // [R2]
      2'h1:    div_mask = DIV8_MASK;   // [R2]
      2'h2:    div_mask = DIV16_MASK;  // [R2]
      default: div_mask = DIV64_MASK;  // [R2]
    endcase
    active = run && !clk_stop_i;                        // [R3] [R14]
    tick   = active && ((presc & div_mask) == div_mask);
    match  = tick && (count == cnst);                   // [R5]
  end

  // Prescaler: held at zero while stopped, frozen while clock halted
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      presc <= 6'h00;
    end else if (!run) begin
      presc <= 6'h00;                                   // [R3]
    end else if (!clk_stop_i) begin
      presc <= presc + 6'h01;                           // [R14]
    end
  end

  // Start register
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run <= START_RST[RUN_BIT];                        // [R11]
    end else if (wr_start && w_strb[0]) begin
      run <= w_data[RUN_BIT];                           // [R3]
    end
  end

  // Control fields: request and divider select
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_sel <= CTRL_RST[REQ_LO +: 2];                 // [R11]
      div_sel <= CTRL_RST[DIV_LO +: 2];
    end else if (wr_ctrl && w_strb[0]) begin
      req_sel <= w_data[REQ_LO +: 2];                   // [R6]
      div_sel <= w_data[DIV_LO +: 2];                   // [R2]
    end
  end

  // Counter: bus write first, then match clear, then increment
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= COUNT_RST;                               // [R11]
    end else if (wr_count) begin
      count <= merge16(count, w_data, w_strb);          // [R15]
    end else if (match) begin
      count <= ZERO16;                                  // [R4]
    end else if (tick) begin
      count <= count + 16'h0001;                        // [R1]
    end
  end

  // Match constant
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnst <= CONST_RST;                                // [R11]
    end else if (wr_const) begin
      cnst <= merge16(cnst, w_data, w_strb);            // [R13]
    end
  end

  // Read of the control register with flag high arms the clear
  logic rd_take;
  logic rd_ctrl;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clr_armed <= 1'b0;
    end else if (wr_ctrl) begin
      clr_armed <= 1'b0;
    end else if (rd_take && rd_ctrl && match_flag) begin
      clr_armed <= 1'b1;                                // [R9]
    end
  end

  // Match flag: set wins over a clear in the same cycle
  logic flag_clr;
  assign flag_clr = wr_ctrl && w_strb[0] && !w_data[FLAG_BIT] && clr_armed;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      match_flag <= CTRL_RST[FLAG_BIT];                 // [R11]
    end else if (match) begin
      match_flag <= 1'b1;                               // [R4] [R5]
    end else if (flag_clr) begin
      match_flag <= 1'b0;                               // [R9]
    end
  end

  // DMA request: raised on match, dropped on acceptance
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dma_req_o <= 1'b0;
    end else if (match && req_sel == REQ_DMA) begin
      dma_req_o <= 1'b1;                                // [R6]
    end else if (dma_ack_i) begin
      dma_req_o <= 1'b0;                                // [R7]
    end
  end

  // Match interrupt follows the flag while interrupt requests selected
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      match_irq_o <= 1'b0;
    end else begin
      match_irq_o <= match_flag && (req_sel == REQ_IRQ); // [R6] [R8]
    end
  end

  // Sticky event status, write one to clear, set wins
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      evt_stat <= 1'b0;
    end else if (match) begin
      evt_stat <= 1'b1;
    end else if (wr_stat && w_strb[0] && w_data[0]) begin
      evt_stat <= 1'b0;
    end
  end

  // Event mask
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      evt_mask <= 1'b0;
    end else if (wr_mask && w_strb[0]) begin
      evt_mask <= w_data[0];
    end
  end

  // Masked event interrupt
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= evt_stat && evt_mask;
    end
  end

  // Write address and data channels, taken in either order
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_full       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      w_full       <= 1'b0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_full <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read decode; reserved bits read as zero
  logic [31:0] rd_val;
  logic        rd_hit;
  logic [11:0] ra;

  always_comb begin
    rd_take = s_axi_arvalid && s_axi_arready;
    ra      = s_axi_araddr[11:0];
    rd_val  = 32'h00000000;
    rd_hit  = 1'b1;
    rd_ctrl = 1'b0;
    if (ra == START_ADDR) begin
      rd_val[RUN_BIT] = run;                            // [R10]
    end else if (ra == CTRL_ADDR) begin
      rd_ctrl             = 1'b1;
      rd_val[FLAG_BIT]    = match_flag;                 // [R10]
      rd_val[REQ_LO +: 2] = req_sel;
      rd_val[DIV_LO +: 2] = div_sel;
    end else if (ra == COUNT_ADDR) begin
      rd_val[15:0] = count;
    end else if (ra == CONST_ADDR) begin
      rd_val[15:0] = cnst;                              // [R13]
    end else if (ra == IRQ_STAT_ADDR) begin
      rd_val[0] = evt_stat;
    end else if (ra == IRQ_MASK_ADDR) begin
      rd_val[0] = evt_mask;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // No standby input exists: registers only change by reset, bus, counting or DMA acknowledge [R12]

endmodule : cmit_timer

//--- cmit_timer_properties.sv
// Checker for bus handshakes and request outputs of the timer.
// Assumes it is bound to cmit_timer and sees only its ports.
`timescale 1ns/1ps
module cmit_timer_properties (
  input wire logic ref_clk_i,     // Clock
  input wire logic rst_b_i,       // Reset, low
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wvalid,  // W valid
  input wire logic s_axi_wready,  // W ready
  input wire logic s_axi_bvalid,  // B valid
  input wire logic s_axi_bready,  // B ready
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic s_axi_rvalid,  // R valid
  input wire logic clk_stop_i,    // Clock halt
  input wire logic dma_ack_i,     // DMA accept
  input wire logic dma_req_o,     // DMA request
  input wire logic match_irq_o,   // Match interrupt
  input wire logic irq_o          // Event interrupt
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Bus answer timing and holding
  AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write answer late");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  // Requests towards DMA and interrupt controllers
  AST_DMA_DROP: assert property ($fell(dma_req_o) |-> $past(dma_ack_i))
    else $error("DMA request dropped without accept");
  AST_DMA_HOLD: assert property (dma_req_o && !dma_ack_i |=> dma_req_o)
    else $error("DMA request lost");
  AST_IRQ_HOLD: assert property ($fell(match_irq_o) |-> $past(s_axi_bvalid))
    else $error("match interrupt dropped without write");
  AST_IRQ_CLR: assert property ($fell(irq_o) |-> $past(s_axi_bvalid))
    else $error("event interrupt dropped without write");
  AST_REQ_EXCL: assert property (!(dma_req_o && match_irq_o))
    else $error("both requests raised");
  AST_STOP: assert property ($past(clk_stop_i, 2) |-> !$rose(dma_req_o))
    else $error("request while clock halted");
endmodule : cmit_timer_properties

bind cmit_timer cmit_timer_properties u_props (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .clk_stop_i(clk_stop_i),
  .dma_ack_i(dma_ack_i), .dma_req_o(dma_req_o), .match_irq_o(match_irq_o), .irq_o(irq_o)
);

//--- cmit_dma_model.sv
// DMA controller model: accepts each timer request after a set wait.
// Assumes the timer clock and reset domain.
`timescale 1ns/1ps
module cmit_dma_model (
  input  wire logic       clk_i,   // Timer clock
  input  wire logic       rst_b_i, // Reset, low
  input  wire logic       req_i,   // DMA request
  input  wire logic [3:0] wait_i,  // Cycles before accept
  output logic            ack_o    // Accept pulse
);
  logic [3:0] cnt;
  // One accept pulse per request, prompt or slow
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 4'h0;
      ack_o <= 1'b0;
    end else begin
      ack_o <= 1'b0;
      if (!req_i || ack_o) cnt <= 4'h0;
      else if (cnt == wait_i) ack_o <= 1'b1;
      else cnt <= cnt + 4'h1;
    end
  end
endmodule : cmit_dma_model

//--- compare_match_interval_timer_test.sv
// Self-checking bench for the interval timer over AXI4-Lite.
// Assumes cmit_pkg, cmit_timer and cmit_dma_model are compiled first.
`timescale 1ns/1ps
module compare_match_interval_timer_test import cmit_pkg::*; ;
  logic        ref_clk_i = 1'b0, rst_b_i = 1'b0, clk_stop_i = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, rdv;
  logic [3:0]  s_axi_wstrb = 4'h3, ack_wait = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bresp, rresp;
  logic [31:0] s_axi_rdata;
  logic        dma_ack_i, dma_req_o, match_irq_o, irq_o;
  logic [15:0] v;
  logic [11:0] ra [6] = '{START_ADDR, CTRL_ADDR, COUNT_ADDR, CONST_ADDR,
                          IRQ_STAT_ADDR, IRQ_MASK_ADDR};
  int          errors = 0, n_compared = 0, cyc = 0, t_wr, t_sig, t0, c;

  // Clock and edge count
  always #25 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) cyc <= cyc + 1;

  cmit_timer #(.ADDR_W(12)) dut (.*);
  cmit_dma_model u_dma (.clk_i(ref_clk_i), .rst_b_i(rst_b_i), .req_i(dma_req_o),
                        .wait_i(ack_wait), .ack_o(dma_ack_i));

  // Interval in clocks from divider code and constant
  function automatic int period(input int d, input int k);
    return (k + 1) * (d == 3 ? 64 : 4 << d);
  endfunction : period

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tmo();
    chk(32'h0, 32'h1);
    results();
  endtask : tmo

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  // Bus write: address and data together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk_i);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    bresp = s_axi_bresp;
    t_wr = cyc;
    if (n == 50) tmo();
    // Let an edge pass so the next call never re-raises bready in this step
    @(posedge ref_clk_i);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk_i);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    rdv = s_axi_rdata;
    rresp = s_axi_rresp;
    if (n == 50) tmo();
    // Let an edge pass so the next call never re-raises rready in this step
    @(posedge ref_clk_i);
  endtask : rd

  // Wait for a request output to reach a level
  task automatic wsig(input logic irq, input logic lvl);
    int n;
    for (n = 0; n < 2000; n++) begin
      @(posedge ref_clk_i);
      if ((irq ? match_irq_o : dma_req_o) === lvl) break;
    end
    t_sig = cyc;
    if (n == 2000) tmo();
  endtask : wsig

  // Main sequence
  initial begin
    void'($urandom(32'h664D20AC));
    repeat (8) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    @(posedge ref_clk_i);
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(rdv, i == 3 ? 32'h0000FFFF : 32'h0);
    end
    done("reset");
    wr(START_ADDR, 32'h0000FFFE);
    rd(START_ADDR);
    chk(rdv, 32'h0);
    wr(CTRL_ADDR, 32'h0000FF4F);
    rd(CTRL_ADDR);
    chk(rdv, 32'h3);
    v = 16'($urandom);
    wr(CONST_ADDR, {16'h0, v});
    rd(CONST_ADDR);
    chk(rdv, {16'h0, v});
    wr(12'h004, 32'h1);
    chk(32'(bresp), 32'(RESP_SLVERR));
    rd(12'h004);
    chk(32'(rresp), 32'(RESP_SLVERR));
    chk(rdv, 32'h0);
    done("registers");
    // Every divider code, DMA request, flag clearing
    for (int d = 0; d < 4; d++) begin
      c = $urandom % 5;
      ack_wait <= (d == 3) ? 4'hC : 4'h0;
      wr(START_ADDR, 32'h0);
      wr(COUNT_ADDR, 32'h0);
      wr(CONST_ADDR, 32'(c));
      wr(CTRL_ADDR, 32'h10 | 32'(d));
      wr(START_ADDR, 32'h1);
      t0 = t_wr;
      wsig(1'b0, 1'b1);
      chk(32'(t_sig - t0), 32'(period(d, c)));
      t0 = t_sig;
      wsig(1'b0, 1'b0);
      wsig(1'b0, 1'b1);
      chk(32'(t_sig - t0), 32'(period(d, c)));
      wsig(1'b0, 1'b0);
      wr(START_ADDR, 32'h0);
      rd(CTRL_ADDR);
      chk(rdv, 32'h90 | 32'(d));
      wr(CTRL_ADDR, 32'h90 | 32'(d));
      wr(CTRL_ADDR, 32'h10 | 32'(d));
      rd(CTRL_ADDR);
      chk(rdv, 32'h90 | 32'(d));
      wr(CTRL_ADDR, 32'h10 | 32'(d));
      rd(CTRL_ADDR);
      chk(rdv, 32'h10 | 32'(d));
    end
    done("interval");
    // Interrupt request, event status and mask
    wr(IRQ_STAT_ADDR, 32'h1);
    wr(CTRL_ADDR, 32'h20);
    wr(CONST_ADDR, 32'h2);
    wr(COUNT_ADDR, 32'h0); // Leftover count above 2 would wrap first
    wr(START_ADDR, 32'h1);
    wsig(1'b1, 1'b1);
    wr(START_ADDR, 32'h0);
    chk(32'(irq_o), 32'h0);
    repeat (20) @(posedge ref_clk_i);
    chk(32'(match_irq_o), 32'h1);
    chk(32'(dma_req_o), 32'h0);
    wr(IRQ_MASK_ADDR, 32'h1);
    @(posedge ref_clk_i);
    chk(32'(irq_o), 32'h1);
    wr(IRQ_STAT_ADDR, 32'h1);
    @(posedge ref_clk_i);
    chk(32'(irq_o), 32'h0);
    rd(CTRL_ADDR);
    wr(CTRL_ADDR, 32'h20);
    @(posedge ref_clk_i);
    chk(32'(match_irq_o), 32'h0);
    done("interrupt");
    // Halted clock supply and run bit freeze the counter
    v = 16'($urandom);
    wr(CTRL_ADDR, 32'h0);
    wr(CONST_ADDR, 32'h0000FFFF);
    wr(COUNT_ADDR, {16'h0, v});
    clk_stop_i <= 1'b1;
    wr(START_ADDR, 32'h1);
    repeat (40) @(posedge ref_clk_i);
    rd(COUNT_ADDR);
    chk(rdv, {16'h0, v});
    clk_stop_i <= 1'b0;
    repeat (40) @(posedge ref_clk_i);
    wr(START_ADDR, 32'h0);
    rd(COUNT_ADDR);
    chk(32'(rdv != {16'h0, v}), 32'h1);
    t0 = int'(rdv);
    repeat (40) @(posedge ref_clk_i);
    rd(COUNT_ADDR);
    chk(rdv, 32'(t0));
    done("halt");
    results();
  end
endmodule : compare_match_interval_timer_test
